//--- inc/pfts_params.svh
// constants for the pwm fault and time base sync block
// assumes inclusion by bare name from the design file and the testbench
`ifndef PFTS_PARAMS_SVH
`define PFTS_PARAMS_SVH
// register offsets (byte addresses on the plain register port)
`define PFTS_ADDR_SETUP   8'h00
`define PFTS_ADDR_FLTCFG  8'h04
`define PFTS_ADDR_SAFE    8'h08
`define PFTS_ADDR_COUNTER 8'h0c
`define PFTS_ADDR_STATUS  8'h10
`define PFTS_ADDR_MASK    8'h14
`define PFTS_ADDR_MODULO  8'h18
// setup register fields
`define PFTS_SETUP_COUNTER_CLOCK_SELECT_LO 0
`define PFTS_SETUP_TBEN    2
`define PFTS_SETUP_TBOUT   3
`define PFTS_SETUP_SCOPE_LO 4
// fault config register fields
`define PFTS_FLT_POL_LO    0
`define PFTS_FLT_EN_LO     4
`define PFTS_FLT_PAIR_LO   8
// status bit positions
`define PFTS_ST_FAULT      0
`define PFTS_ST_OVF        1
`define PFTS_ST_RELOAD     2
`define PFTS_ST_CMP        3
`define PFTS_ST_CAP        4
// reset values, scope mode codes and the stop clock select code
`define PFTS_MODULO_RST    16'hffff
`define PFTS_SCOPE_AUTO    2'h3
`define PFTS_SCOPE_EVEN    2'h1
`define PFTS_COUNTER_CLOCK_SELECT_STOP     2'h0
`endif

//--- inc/pfts_pkg.sv
// types for the pwm fault and time base sync block
// assumes the params header is on the include path
package pfts_pkg;
    // counter clock select codes
    typedef enum logic [1:0] {
        PFTS_CLK_STOP = 2'h0,
        PFTS_CLK_FUNC = 2'h1,
        PFTS_CLK_FIX  = 2'h2,
        PFTS_CLK_EXT  = 2'h3
    } pfts_counter_clock_select_t;
    // counter run state, one-hot
    typedef enum logic [2:0] {
        PFTS_IDLE = 3'h1,
        PFTS_WAIT = 3'h2,
        PFTS_RUN  = 3'h4
    } pfts_run_t;
endpackage

//--- hdl/pfts_core.sv
// fault protection and global time base sync of a pwm timer
// assumes one 250 MHz clock, synchronous inputs, plain register port
//
// What this block and the software driving it do
// R1: active fault stops pwm on enabled channels
// R2: fault can raise an interrupt request
// R3: all interrupt sources share one line
// R4: faulted outputs forced to safe level bit
// R5: all fault inputs ORed, no per-channel routing
// R6: pair fault enable gates fault per pair
// R7: scope mode picks all or even channels
// R8: scope 0x3 means all channels, auto clear
// R9: polarity bit clear means high is fault
// R10: synced timers hold identical counter values
// R11: leader output starts all participating counters
// R12: all timers share clock, start together
// R13: software stops counter with clock select 00b
// R14: software sets same counting mode everywhere
// R15: software sets enable=1, output=0 in one write
// R16: software selects identical clock after enabling
// R17: any counter write resets the counter
// R18: software sets leader output to start all
// R19: enabled timer waits for sync before counting
`timescale 1ns/1ps
`include "pfts_params.svh"
module pfts_core (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // register port
    input  wire logic [7:0]   regAddr,
    input  wire logic [31:0]  regWrData,
    input  wire logic         regWrite,
    input  wire logic         regRead,
    output logic      [31:0]  regRdData,
    // fault inputs from protection circuits
    input  wire logic [3:0]   faultIn,
    // pwm from waveform logic, and events from the rest of the timer
    input  wire logic [7:0]   pwmIn,
    input  wire logic         cmpEvent,
    input  wire logic         capEvent,
    // global time base link with peer timers
    input  wire logic         syncIn,
    output logic              syncOut,
    // pin side
    output logic      [7:0]   chanOut,
    output logic      [7:0]   chanOe,
    output logic      [15:0]  counterValue,
    output logic              irq
);
    import pfts_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    pfts_counter_clock_select_t  clkSel;         // counter clock select
    logic        tbEnable;       // time base enable
    logic        tbOutput;       // time base output (leader)
    logic [1:0]  scopeMode;      // fault scope mode
    logic [3:0]  fltPolarity;    // 1 means input is active low
    logic [3:0]  fltInEnable;    // per input fault enable
    logic [3:0]  pairFaultEn;    // per pair fault enable
    logic [7:0]  safeLevel;      // safe level per channel
    logic [15:0] modulo;         // counter wrap value
    logic [4:0]  status;         // sticky event flags
    logic [4:0]  mask;           // interrupt mask
    logic        faultLatch;     // held fault for manual clear modes
    pfts_run_t   runState;       // counter run state

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire wrSetup  = regWrite && regAddr == `PFTS_ADDR_SETUP;
    wire wrFlt    = regWrite && regAddr == `PFTS_ADDR_FLTCFG;
    wire wrSafe   = regWrite && regAddr == `PFTS_ADDR_SAFE;
    wire wrCnt    = regWrite && regAddr == `PFTS_ADDR_COUNTER;
    wire wrStatus = regWrite && regAddr == `PFTS_ADDR_STATUS;
    wire wrMask   = regWrite && regAddr == `PFTS_ADDR_MASK;
    wire wrMod    = regWrite && regAddr == `PFTS_ADDR_MODULO;

    // ------------------------------------------------------------
    // fault merge
    // ------------------------------------------------------------
    // active-high view of each input; one OR for all, no routing
    wire [3:0] fltActive = (faultIn ^ fltPolarity) & fltInEnable; // [R9]
    wire       faultRaw  = |fltActive;                            // [R5]
    // auto mode follows the input; other modes hold until cleared
    wire       autoClear = scopeMode == `PFTS_SCOPE_AUTO;         // [R8]
    wire       faultNow  = faultRaw || (!autoClear && faultLatch);
    // scope mode 0 leaves fault control off
    wire       scopeOn   = scopeMode != 2'h0;

    // ------------------------------------------------------------
    // per channel forcing
    // ------------------------------------------------------------
    logic [7:0] chanFault;      // channel is held by the fault
    logic [7:0] next_chanOut;   // pin value after forcing
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            // odd channels skip in even-only scope and when scope is off
            wire inScope = scopeOn && ((gi % 2 == 0) ||
                           scopeMode != `PFTS_SCOPE_EVEN);        // [R7]
            assign chanFault[gi] = faultNow && inScope &&
                                   pairFaultEn[gi/2];             // [R6]
            assign next_chanOut[gi] = chanFault[gi] ?
                                   safeLevel[gi] : pwmIn[gi];     // [R1] [R4]
        end
    endgenerate

    // ------------------------------------------------------------
    // counter with global time base start
    // ------------------------------------------------------------
    logic [15:0] count;         // free counter
    wire   clkOn   = clkSel != PFTS_CLK_STOP;
    wire   wrap    = count == modulo;
    // the leader's own output starts it too, since it has no loop back
    wire   syncSeen = syncIn || tbOutput;
    wire   counting = runState == PFTS_RUN && clkOn;
    wire   reloadPt = counting && count == (modulo >> 1);
    pfts_run_t next_run;
    always_comb begin
        next_run = runState;
        unique case (runState)
            PFTS_IDLE: if (clkOn)
                next_run = tbEnable ? PFTS_WAIT : PFTS_RUN;   // [R19]
            PFTS_WAIT: if (!clkOn) next_run = PFTS_IDLE;
                else if (syncSeen) next_run = PFTS_RUN;      // [R11]
            PFTS_RUN:  if (!clkOn) next_run = PFTS_IDLE;
            default:   next_run = PFTS_IDLE;
        endcase
    end

    // run state flop
    always_ff @(posedge ref_clk) begin
        if (!reset_n) runState <= PFTS_IDLE;
        else          runState <= next_run;
    end

    // counter: any write resets it, so peers start from zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n)      count <= 16'h0000;
        else if (wrCnt)    count <= 16'h0000;                // [R17]
        else if (counting) count <= wrap ? 16'h0000
                                         : count + 16'h0001; // [R10]
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            clkSel      <= PFTS_CLK_STOP;
            tbEnable    <= 1'b0;
            tbOutput    <= 1'b0;
            scopeMode   <= 2'h0;
        end else if (wrSetup) begin
            clkSel      <= pfts_counter_clock_select_t'(regWrData[`PFTS_SETUP_COUNTER_CLOCK_SELECT_LO +: 2]);
            tbEnable    <= regWrData[`PFTS_SETUP_TBEN];
            tbOutput    <= regWrData[`PFTS_SETUP_TBOUT];
            scopeMode   <= regWrData[`PFTS_SETUP_SCOPE_LO +: 2];
        end
    end

    // fault input and pair configuration
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fltPolarity <= 4'h0;
            fltInEnable <= 4'h0;
            pairFaultEn <= 4'h0;
        end else if (wrFlt) begin
            fltPolarity <= regWrData[`PFTS_FLT_POL_LO +: 4];
            fltInEnable <= regWrData[`PFTS_FLT_EN_LO +: 4];
            pairFaultEn <= regWrData[`PFTS_FLT_PAIR_LO +: 4];
        end
    end

    // safe levels, modulo, mask
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            safeLevel <= 8'h00;
            modulo    <= `PFTS_MODULO_RST;
            mask      <= 5'h00;
        end else begin
            if (wrSafe) safeLevel <= regWrData[7:0];
            if (wrMod)  modulo    <= regWrData[15:0];
            if (wrMask) mask      <= regWrData[4:0];
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    wire [4:0] events;
    assign events[`PFTS_ST_FAULT]  = faultRaw && scopeOn;          // [R2]
    assign events[`PFTS_ST_OVF]    = counting && wrap;
    assign events[`PFTS_ST_RELOAD] = reloadPt;
    assign events[`PFTS_ST_CMP]    = cmpEvent;
    assign events[`PFTS_ST_CAP]    = capEvent;
    wire [4:0] clearBits = wrStatus ? regWrData[4:0] : 5'h00;
    // set beats clear in the same cycle
    wire [4:0] next_status = (status & ~clearBits) | events;
    // mask as it stands after this edge, so irq never lags a mask write
    // and always matches the flags and mask that software can read
    wire [4:0] next_mask   = wrMask ? regWrData[4:0] : mask;

    // sticky flags; manual modes hold the fault until its flag clears
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status     <= 5'h00;
            faultLatch <= 1'b0;
        end else begin
            status     <= next_status;
            faultLatch <= next_status[`PFTS_ST_FAULT];
        end
    end

    // ------------------------------------------------------------
    // read mux and outputs
    // ------------------------------------------------------------
    logic [31:0] next_rd;
    always_comb begin
        next_rd = 32'h0000_0000;
        unique case (regAddr)
            `PFTS_ADDR_SETUP:   next_rd = {26'h0, scopeMode, tbOutput,
                                           tbEnable, clkSel};
            `PFTS_ADDR_FLTCFG:  next_rd = {20'h0, pairFaultEn,
                                           fltInEnable, fltPolarity};
            `PFTS_ADDR_SAFE:    next_rd = {24'h0, safeLevel};
            `PFTS_ADDR_COUNTER: next_rd = {16'h0, count};
            `PFTS_ADDR_STATUS:  next_rd = {27'h0, status};
            `PFTS_ADDR_MASK:    next_rd = {27'h0, mask};
            `PFTS_ADDR_MODULO:  next_rd = {16'h0, modulo};
            default:            next_rd = 32'h0000_0000;
        endcase
    end

    // every output registered
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            regRdData    <= 32'h0000_0000;
            chanOut      <= 8'h00;
            chanOe       <= 8'h00;
            counterValue <= 16'h0000;
            irq          <= 1'b0;
            syncOut      <= 1'b0;
        end else begin
            regRdData    <= regRead ? next_rd : 32'h0000_0000;
            chanOut      <= next_chanOut;
            chanOe       <= ~chanFault;       // driver off, not pwm, in fault
            counterValue <= count;
            irq          <= |(next_status & next_mask);     // [R3]
            syncOut      <= tbOutput;                       // [R11]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_safe_level_forced: assert property (@(posedge ref_clk)
        disable iff (!reset_n) chanFault[0] |=> chanOut[0] ==
        $past(safeLevel[0])) else $error("safe level not forced"); // [R4]
    a_odd_spared_even: assert property (@(posedge ref_clk)
        disable iff (!reset_n) scopeMode == `PFTS_SCOPE_EVEN |->
        !chanFault[1]) else $error("odd channel faulted"); // [R7]
    a_pair_gate: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !pairFaultEn[0] |-> chanFault[1:0] == 2'h0)
        else $error("pair not gated"); // [R6]
    a_or_merge: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (autoClear && pairFaultEn[0] && fltActive
        != 4'h0) |=> !chanOe[0]) else $error("fault not merged"); // [R5]
    a_auto_release: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (autoClear && !faultRaw) |-> !chanFault[0])
        else $error("auto clear held fault"); // [R8]
    a_high_is_fault: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (!fltPolarity[0] && fltInEnable[0] &&
        faultIn[0] && scopeOn) |=> status[`PFTS_ST_FAULT])
        else $error("high input missed"); // [R9] [R2]
    a_stopped_pwm: assert property (@(posedge ref_clk)
        disable iff (!reset_n) chanFault[2] |=> chanOe[2] == 1'b0)
        else $error("pwm not stopped"); // [R1]
    a_irq_follows: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (status & mask) != 5'h00 |-> irq)
        else $error("irq missing"); // [R3]
    a_wait_sync: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (runState == PFTS_WAIT && !syncSeen &&
        !wrCnt) |=> $stable(count)) else $error("counted early"); // [R19]
    a_count_reset: assert property (@(posedge ref_clk)
        disable iff (!reset_n) wrCnt |=> count == 16'h0000)
        else $error("counter not reset"); // [R17]
    a_lockstep_run: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (counting && !wrap && !wrCnt) |=>
        count == $past(count) + 16'h0001) else $error("count skip"); // [R10]

    // ------------------------------------------------------------
    // further checks on scope, start and interrupt
    // ------------------------------------------------------------
    // scope mode 0 must leave every channel free
    a_scope_off: assert property (@(posedge ref_clk)
        disable iff (!reset_n) scopeMode == 2'h0 |-> chanFault == 8'h00)
        else $error("fault applied with scope off"); // [R7]
    // even channels still follow the fault in even-only scope
    a_even_forced: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (scopeMode == `PFTS_SCOPE_EVEN &&
        faultNow && pairFaultEn[0]) |-> chanFault[0])
        else $error("even channel not faulted"); // [R7]
    // a channel not held by the fault keeps its driver on
    a_oe_free: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !chanFault[3] |=> chanOe[3])
        else $error("free channel disabled"); // [R1]
    // the fault flag stays until software writes it clear
    a_fault_sticky: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (status[`PFTS_ST_FAULT] && !wrStatus) |=>
        status[`PFTS_ST_FAULT]) else $error("fault flag lost"); // [R2]
    // no unmasked flag, no request on the shared line
    a_irq_quiet: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (status & mask) == 5'h00 |-> !irq)
        else $error("irq without source"); // [R3]
    // an enabled timer parks in wait instead of counting
    a_enable_waits: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (runState == PFTS_IDLE && clkOn &&
        tbEnable) |=> runState == PFTS_WAIT)
        else $error("time base skipped wait"); // [R19]
    // the start line moves a waiting timer into run
    a_start_runs: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (runState == PFTS_WAIT && clkOn &&
        syncSeen) |=> runState == PFTS_RUN)
        else $error("start not taken"); // [R11]
    // the leader bit reaches the link one cycle later
    a_sync_copy: assert property (@(posedge ref_clk)
        disable iff (!reset_n) tbOutput |=> syncOut)
        else $error("sync not driven"); // [R11]
    // a stopped clock select freezes the counter
    a_stop_holds: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (!clkOn && !wrCnt) |=> $stable(count))
        else $error("stopped counter moved"); // [R13]
endmodule

//--- testbench/pfts_far_side.sv
// far side model: fault sensors and the leader timer's start line
// assumes the bench drives requests just after a rising edge
`timescale 1ns/1ps
module pfts_far_side (
    // requests from the bench
    input  wire logic [3:0] faultReq,
    input  wire logic [3:0] faultLow,
    input  wire logic       startReq,
    // lines into the timer
    output logic      [3:0] faultIn,
    output logic            syncIn
);
    // --------------------------------------------------
    // pin levels
    // --------------------------------------------------
    // a sensor pulls its pin high on a fault unless wired active low
    assign faultIn = faultReq ^ faultLow;
    // one common start level reaches every peer at the same edge
    assign syncIn  = startReq;
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the fault and time base sync block
// assumes the far side model and the design files are compiled first
`timescale 1ns/1ps
`include "pfts_params.svh"
module tb_top;
    import pfts_pkg::*;
    // --------------------------------------------------
    // signals
    // --------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regRdData;
    logic [3:0]  faultIn;
    logic [3:0]  faultReq = 4'h0;
    logic [3:0]  faultLow = 4'h0;
    logic [7:0]  pwmIn = 8'h00;
    logic        cmpEvent = 1'b0;
    logic        capEvent = 1'b0;
    logic        startReq = 1'b0;
    logic        syncIn;
    logic        syncOut;
    logic        irq;
    logic [7:0]  chanOut;
    logic [7:0]  chanOe;
    logic [15:0] counterValue;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    logic [31:0] seed = 32'hac31a1f3;  // fixed so runs repeat
    // 250 MHz
    always #2 ref_clk = ~ref_clk;
    pfts_core i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .faultIn(faultIn),
        .pwmIn(pwmIn), .cmpEvent(cmpEvent), .capEvent(capEvent),
        .syncIn(syncIn), .syncOut(syncOut), .chanOut(chanOut),
        .chanOe(chanOe), .counterValue(counterValue), .irq(irq));
    pfts_far_side i_far (.faultReq(faultReq), .faultLow(faultLow),
        .startReq(startReq), .faultIn(faultIn), .syncIn(syncIn));
    // --------------------------------------------------
    // helpers
    // --------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected {enables, pins}; a forced pin shows its safe level
    function automatic logic [15:0] expPins(input logic [1:0] scope,
        input logic [3:0] pe, input logic [7:0] sf,
        input logic [7:0] pw, input logic on);
        logic [7:0] f;
        for (int c = 0; c < 8; c++)
            f[c] = on && pe[c / 2] && scope != 2'h0
                   && (scope != `PFTS_SCOPE_EVEN || c % 2 == 0);
        return {~f, (f & sf) | (~f & pw)};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge ref_clk);
        regWrite  <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // --------------------------------------------------
    // main sequence
    // --------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] d2;
        logic [1:0]  scope;
        logic [3:0]  pe;
        logic [3:0]  lo;
        logic [7:0]  sf;
        logic [7:0]  pw;
        logic        m;
        int          k;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(`PFTS_ADDR_MODULO, d);
        check(d, {16'h0, `PFTS_MODULO_RST});
        rd(8'h1c, d);
        check(d, 32'h0);
        // every scope mode twice, random pairs, levels and pwm
        for (int i = 0; i < 8; i++) begin
            scope = 2'(i / 2);
            pe = 4'(rnd());
            lo = 4'(rnd());
            sf = 8'(rnd());
            pw = 8'(rnd());
            m  = rnd() % 2;
            pwmIn    <= pw;
            // pin and polarity change at one edge: no false fault
            wr(`PFTS_ADDR_FLTCFG, {20'h0, pe, 4'hf, lo});
            faultLow <= lo;
            wr(`PFTS_ADDR_SAFE, {24'h0, sf});
            wr(`PFTS_ADDR_MASK, {31'h0, m});
            wr(`PFTS_ADDR_SETUP, {26'h0, scope, 4'h0});
            faultReq <= 4'h1 << (rnd() % 4);
            cyc(3);
            check({chanOe, chanOut}, expPins(scope, pe, sf, pw, 1'b1));
            check(irq, m && scope != 2'h0);
            faultReq <= 4'h0;
            cyc(3);
            check({chanOe, chanOut}, expPins(scope, pe, sf, pw, scope == 2'h1 || scope == 2'h2));
            wr(`PFTS_ADDR_STATUS, 32'h1f);
            cyc(3);
            check({chanOe, chanOut}, expPins(scope, pe, sf, pw, 1'b0));
            check(irq, 1'b0);
        end
        // compare raises the single request line; capture is masked and only sets its flag
        wr(`PFTS_ADDR_MASK, 32'h8);
        cmpEvent <= 1'b1;
        capEvent <= 1'b1;
        @(posedge ref_clk);
        cmpEvent <= 1'b0;
        capEvent <= 1'b0;
        cyc(2);
        check(irq, 1'b1);
        rd(`PFTS_ADDR_STATUS, d);
        check(d & 32'h19, 32'h18);
        wr(`PFTS_ADDR_STATUS, 32'h1f);
        // follower set-up: stop, enable, clock, counter reset
        wr(`PFTS_ADDR_SETUP, 32'h0);
        wr(`PFTS_ADDR_SETUP, 32'h4);
        wr(`PFTS_ADDR_SETUP, 32'h5);
        wr(`PFTS_ADDR_COUNTER, rnd());
        cyc(10);
        rd(`PFTS_ADDR_COUNTER, d);
        check(d, 32'h0);
        check(syncOut, 1'b0);
        startReq <= 1'b1;
        cyc(4);
        k = rnd() % 40;
        rd(`PFTS_ADDR_COUNTER, d);
        cyc(k);
        rd(`PFTS_ADDR_COUNTER, d2);
        check(d2 - d, k + 2);
        wr(`PFTS_ADDR_COUNTER, rnd());
        rd(`PFTS_ADDR_COUNTER, d);
        check(d, 32'h1);
        check(counterValue, 16'h0001);
        // this timer as leader drives its output bit out on syncOut
        startReq <= 1'b0;
        wr(`PFTS_ADDR_SETUP, 32'hd);
        k = 0;
        while (syncOut !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        check(syncOut, 1'b1);
        summarize();
    end
endmodule
